// >>> logic/eqs_device.sv
// Equalizer end: receives control words and holds band and gain settings.
`default_nettype none

module eqs_device
	import eqs_pkg::*;
(
	input  wire logic                          clk_sys,
	input  wire logic                          reset,
	eqs_link_if.dev                            link,
	output logic [eqs_pkg::BAND_W-1:0]         band_sel_q,
	output logic [eqs_pkg::NUM_BANDS-1:0]
	             [eqs_pkg::GAIN_W-1:0]         band_gain_q,
	output logic [eqs_pkg::NUM_BANDS-1:0]      band_open_q,
	output logic                               range_6db_q,
	output logic [eqs_pkg::WORD_W-1:0]         last_word_q,
	output logic                               word_taken_q,
	output logic                               word_reject_q
);
	import eqs_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers.
	//
	// The three link wires are the only control inputs. Each passes two
	// flops before any logic looks at it; stage 0 feeds stage 1 only.

	logic [1:0] clk_sync_q;  // Shift clock synchroniser.
	logic [1:0] dat_sync_q;  // Serial data synchroniser.
	logic [1:0] stb_sync_q;  // Latch strobe synchroniser.

	// Two-stage capture of the link wires.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			clk_sync_q <= 2'h0;
			dat_sync_q <= 2'h0;
			stb_sync_q <= 2'h3;
		end else begin
			clk_sync_q <= {clk_sync_q[0], link.shift_clk};
			dat_sync_q <= {dat_sync_q[0], link.ser_data};
			stb_sync_q <= {stb_sync_q[0], link.latch_pulse_n};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Edge detection on the synchronised wires.

	logic clk_prev_q;  // Shift clock one cycle ago.
	logic stb_prev_q;  // Strobe one cycle ago.
	logic clk_rise;    // Shift clock went high.
	logic stb_done;    // Strobe returned high, ending the pulse.

	// Previous values; the strobe idles high so it resets high.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			clk_prev_q <= 1'b0;
			stb_prev_q <= 1'b1;
		end else begin
			clk_prev_q <= clk_sync_q[1];
			stb_prev_q <= stb_sync_q[1];
		end
	end

	assign clk_rise = clk_sync_q[1] & ~clk_prev_q;
	// The transfer waits for the rising end of the strobe, so a
	// pulse that is cut short still ends with one clean transfer.
	assign stb_done = stb_sync_q[1] & ~stb_prev_q;

	////////////////////////////////////////////////////////////////////////
	// Serial shift register.
	//
	// A new bit enters at the top and moves down, so after eight edges
	// the first bit sent sits at bit 0 of the word.

	logic [WORD_W-1:0] shift_q;  // Bits gathered so far.
	logic [CNT_W-1:0]  count_q;  // Rising edges since the last strobe.

	// Shift on every rising edge of the shift clock.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			shift_q <= '0;
		end else if (clk_rise) begin
			shift_q <= {dat_sync_q[1], shift_q[WORD_W-1:1]};
		end
	end

	// Edge count; saturates so a long burst cannot wrap to eight.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			count_q <= '0;
		end else if (stb_done) begin
			count_q <= '0;
		end else if (clk_rise && count_q != '1) begin
			count_q <= count_q + CNT_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Word decode.
	//
	// Bit 7 set marks a band-select word: bits 3..0 name the band and
	// bit 6 picks the range. Bit 7 clear marks a gain word: bits 4..0
	// give the step for the band last selected.

	logic              is_band;   // Word selects a band.
	logic [BAND_W-1:0] band_idx;  // Band named by a band word.
	logic [GAIN_W-1:0] gain_step; // Step carried by a gain word.
	logic              band_ok;   // Band index is in range.
	logic              step_ok;   // Gain step is in range.
	logic              full_word; // Exactly eight bits arrived.
	logic              accept;    // Strobe carries a usable word.

	assign is_band   = shift_q[KIND_BIT];
	assign band_idx  = shift_q[BAND_LSB +: BAND_W];
	assign gain_step = shift_q[GAIN_LSB +: GAIN_W];
	assign band_ok   = (32'(band_idx) < NUM_BANDS);
	assign step_ok   = gain_ok(gain_step);
	assign full_word = (32'(count_q) == WORD_W);
	// A word with the wrong bit count or an out-of-range field is
	// dropped whole, so a glitch on the clock cannot corrupt a band.
	assign accept = full_word && (is_band ? band_ok : step_ok);

	////////////////////////////////////////////////////////////////////////
	// Band select and range.
	//
	// A gain word lands on the band chosen by the last accepted band word, or on
	// band BAND_RST before any; the host is expected to send them in that order.

	// Band select and range switch, loaded only on the strobe.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			band_sel_q  <= BAND_RST;
			range_6db_q <= 1'b0;
		end else if (stb_done && accept && is_band) begin
			band_sel_q  <= band_idx;
			range_6db_q <= shift_q[RANGE_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Gain settings and switch state per band.
	//
	// band_open_q high means every switch of that band is open, so
	// the resonator is cut off the resistor network. It is computed
	// here in the flop, not from the gain, to keep outputs registered.

	// Gain and switch state, loaded only on the strobe.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			for (int b = 0; b < NUM_BANDS; b++) begin
				band_gain_q[b] <= FLAT_STEP;
				band_open_q[b] <= 1'b1;
			end
		end else if (stb_done && accept && !is_band) begin
			band_gain_q[band_sel_q] <= gain_step;
			band_open_q[band_sel_q] <= (gain_step == FLAT_STEP);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status outputs.
	//
	// last_word_q shows every strobed word, good or not, which helps
	// when debugging a host with a bad bit order.

	// Strobe result flags are one-cycle pulses.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			last_word_q   <= '0;
			word_taken_q  <= 1'b0;
			word_reject_q <= 1'b0;
		end else begin
			word_taken_q  <= stb_done && accept;
			word_reject_q <= stb_done && !accept;
			if (stb_done) begin
				last_word_q <= shift_q;
			end
		end
	end

	// Clock edges during a strobe are not guarded against: the host
	// keeps clock and data quiet then, and the count check rejects a
	// word that picked up stray edges.

endmodule : eqs_device

`default_nettype wire

// >>> logic/eqs_host.sv
// Host end: sends a band word and a gain word over the three-wire link.
`default_nettype none

module eqs_host
	import eqs_pkg::*;
(
	input  wire logic                       clk_sys,
	input  wire logic                       reset,
	eqs_link_if.host                        link,
	input  wire logic                       start,
	input  wire logic [eqs_pkg::WORD_W-1:0] band_word,
	input  wire logic [eqs_pkg::WORD_W-1:0] gain_word,
	output logic                            busy_q,
	output logic                            done_q
);
	import eqs_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Sequencer states.
	typedef enum logic [2:0] {
		H_IDLE,
		H_LOW,
		H_HIGH,
		H_GAP,
		H_STB_LO,
		H_STB_REC
	} eqs_host_state_e;

	eqs_host_state_e   state_q;  // Current phase of the transfer.
	logic [TMR_W-1:0]  tmr_q;    // Cycles left in the current phase.
	logic [CNT_W-1:0]  bit_q;    // Bits sent of the current word.
	logic [WORD_W-1:0] shift_q;  // Word being sent, next bit at bit 0.
	logic [WORD_W-1:0] gain_hold_q; // Gain word waiting its turn.
	logic              second_q; // Set while the gain word is sent.
	logic              sclk_q;   // Shift clock flop.
	logic              sdat_q;   // Serial data flop.
	logic              stb_n_q;  // Latch strobe flop.
	logic              tick;     // Current phase has run out.

	assign tick = (tmr_q == '0);

	// The link wires come straight from flops, so no glitch reaches them.
	assign link.shift_clk     = sclk_q;
	assign link.ser_data      = sdat_q;
	assign link.latch_pulse_n = stb_n_q;

	////////////////////////////////////////////////////////////////////////
	// Phase sequencer with its timer and outputs.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_q     <= H_IDLE;
			tmr_q       <= '0;
			bit_q       <= '0;
			shift_q     <= '0;
			gain_hold_q <= '0;
			second_q    <= 1'b0;
			sclk_q      <= 1'b0;
			sdat_q      <= 1'b0;
			stb_n_q     <= 1'b1;
			busy_q      <= 1'b0;
			done_q      <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (!tick) begin
				tmr_q <= tmr_q - TMR_W'(1);
			end
			case (state_q)
				// Band word goes first, gain word after it.
				H_IDLE: begin
					if (start) begin
						shift_q     <= band_word;
						gain_hold_q <= gain_word;
						second_q    <= 1'b0;
						bit_q       <= '0;
						sdat_q      <= band_word[0];
						tmr_q       <= HALF_CYC;
						busy_q      <= 1'b1;
						state_q     <= H_LOW;
					end
				end
				// Clock low, data settles before the rising edge.
				H_LOW: begin
					if (tick) begin
						sclk_q  <= 1'b1;
						tmr_q   <= HALF_CYC;
						bit_q   <= bit_q + CNT_W'(1);
						state_q <= H_HIGH;
					end
				end
				// Clock high, data held until the falling edge.
				H_HIGH: begin
					if (tick) begin
						sclk_q <= 1'b0;
						tmr_q  <= HALF_CYC;
						if (32'(bit_q) == WORD_W) begin
							// Clock stops after the last bit.
							sdat_q  <= 1'b0;
							tmr_q   <= CS_CYC;
							state_q <= H_GAP;
						end else begin
							// Next bit, lowest remaining first.
							shift_q <= {1'b0, shift_q[WORD_W-1:1]};
							sdat_q  <= shift_q[1];
							state_q <= H_LOW;
						end
					end
				end
				// Gap from last falling edge to strobe.
				H_GAP: begin
					if (tick) begin
						stb_n_q <= 1'b0;
						tmr_q   <= STB_CYC;
						state_q <= H_STB_LO;
					end
				end
				// Strobe low; clock and data stay quiet.
				H_STB_LO: begin
					if (tick) begin
						stb_n_q <= 1'b1;
						tmr_q   <= REC_CYC;
						state_q <= H_STB_REC;
					end
				end
				// Recovery before any further shifting.
				H_STB_REC: begin
					if (tick) begin
						if (!second_q) begin
							shift_q  <= gain_hold_q;
							sdat_q   <= gain_hold_q[0];
							second_q <= 1'b1;
							bit_q    <= '0;
							tmr_q    <= HALF_CYC;
							state_q  <= H_LOW;
						end else begin
							busy_q  <= 1'b0;
							done_q  <= 1'b1;
							state_q <= H_IDLE;
						end
					end
				end
				default: begin
					state_q <= H_IDLE;
				end
			endcase
		end
	end
	// Clock and data stay still in H_GAP and H_STB_LO; data reloads as H_STB_REC ends after the band word.

endmodule : eqs_host

`default_nettype wire

// >>> logic/eqs_link_if.sv
// Three-wire link between the host end and the equalizer end.
`default_nettype none

interface eqs_link_if;

	logic shift_clk;     // Shift clock, idles low, made by the host.
	logic ser_data;      // Serial data, idles low.
	logic latch_pulse_n; // Latch strobe, idles high, pulses low.

	// The host drives all three wires.
	modport host (
		output shift_clk,
		output ser_data,
		output latch_pulse_n
	);

	// The equalizer end only listens.
	modport dev (
		input shift_clk,
		input ser_data,
		input latch_pulse_n
	);

endinterface : eqs_link_if

`default_nettype wire

// >>> logic/eqs_pkg.sv
// Shared constants and types for the equalizer serial control port.
`default_nettype none

package eqs_pkg;

	// Clock period of clk_sys in nanoseconds (200 MHz).
	localparam int unsigned CLK_NS = 5;

	// Word geometry: eight bits, shifted first bit first.
	localparam int unsigned WORD_W = 8;
	localparam int unsigned CNT_W  = 4;

	// Band and gain geometry: seven bands per channel, two channels.
	localparam int unsigned NUM_BANDS = 14;
	localparam int unsigned BAND_W    = 4;
	localparam int unsigned GAIN_W    = 5;
	localparam int unsigned NUM_STEPS = 25;

	// Word field positions.
	localparam int unsigned KIND_BIT  = 7;
	localparam int unsigned RANGE_BIT = 6;
	localparam int unsigned BAND_LSB  = 0;
	localparam int unsigned GAIN_LSB  = 0;

	// Gain step that means flat; the middle of the 25 steps.
	localparam logic [GAIN_W-1:0] FLAT_STEP = 5'h0C;
	localparam logic [BAND_W-1:0] BAND_RST  = 4'h0;

	// Link timing in nanoseconds, least values.
	localparam int unsigned T_HALF_NS  = 1000;
	localparam int unsigned T_CS_NS    = 1000;
	localparam int unsigned T_STB_NS   = 1000;
	localparam int unsigned T_REC_NS   = 1000;

	// Least times round up to whole cycles.
	localparam int unsigned TMR_W = 8;
	localparam logic [TMR_W-1:0] HALF_CYC =
		TMR_W'((T_HALF_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [TMR_W-1:0] CS_CYC =
		TMR_W'((T_CS_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [TMR_W-1:0] STB_CYC =
		TMR_W'((T_STB_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [TMR_W-1:0] REC_CYC =
		TMR_W'((T_REC_NS + CLK_NS - 1) / CLK_NS);

	// A gain step is legal when it lies within the 25 steps.
	function automatic logic gain_ok(input logic [GAIN_W-1:0] step);
		gain_ok = (32'(step) < NUM_STEPS);
	endfunction

endpackage : eqs_pkg

`default_nettype wire

// >>> sim/eqs_link_props.sv
// Checker for the three-wire link between the host and equalizer ends.
`default_nettype none

module eqs_link_props (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic shift_clk,
	input wire logic ser_data,
	input wire logic latch_pulse_n
);
	timeunit 1ns;
	timeprecision 100ps;

	logic       sclk_q; // Shift clock as seen one cycle ago.
	logic       sdat_q; // Data line as seen one cycle ago.
	logic [7:0] run_q;  // Cycles since the shift clock last moved.
	logic [7:0] dat_q;  // Cycles since the data line last moved.
	logic [7:0] low_q;  // Cycles the strobe has been low.
	logic [3:0] rise_q; // Shift clock rises since the last strobe.

	////////////////////////////////////////////////////////////////////////
	// Counts saturate, so a long idle span never wraps to a small value.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sclk_q <= 1'b0;
			run_q  <= 8'hFF;
		end else begin
			sclk_q <= shift_clk;
			run_q  <= (shift_clk != sclk_q) ? 8'h00 :
				run_q + {7'h00, run_q != 8'hFF};
		end
	end

	// Data age, for setup before each rise.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sdat_q <= 1'b0;
			dat_q  <= 8'hFF;
		end else begin
			sdat_q <= ser_data;
			dat_q  <= (ser_data != sdat_q) ? 8'h00 :
				dat_q + {7'h00, dat_q != 8'hFF};
		end
	end

	// Strobe width and the bit count of the current word.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			low_q  <= 8'h00;
			rise_q <= 4'h0;
		end else begin
			low_q  <= latch_pulse_n ? 8'h00 :
				low_q + {7'h00, low_q != 8'hFF};
			if (!latch_pulse_n) begin
				rise_q <= 4'h0;
			end else if (shift_clk && !sclk_q && rise_q != 4'hF) begin
				rise_q <= rise_q + 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	chk_quiet_strobe: assert property (
		!latch_pulse_n |-> !shift_clk && !ser_data)
		else $error("clock or data active during strobe");
	chk_eight_rises: assert property (
		$fell(latch_pulse_n) |-> rise_q == 4'h8)
		else $error("strobe after a word not of eight bits");
	chk_no_ninth: assert property (
		$rose(shift_clk) |-> rise_q < 4'h8)
		else $error("shift clock rose after the eighth bit");
	chk_half_period: assert property (
		(shift_clk != sclk_q) |-> run_q >= 8'd199)
		else $error("shift clock level too short");
	chk_data_setup: assert property (
		$rose(shift_clk) |-> dat_q >= 8'd199)
		else $error("data setup before rise too short");
	chk_data_hold: assert property (
		(ser_data != sdat_q) |-> !shift_clk && (sclk_q || run_q >= 8'd199))
		else $error("data moved outside the low clock phase");
	chk_clk_to_strobe: assert property (
		$fell(latch_pulse_n) |-> !shift_clk && run_q >= 8'd199)
		else $error("strobe too soon after the last clock");
	chk_strobe_width: assert property (
		$rose(latch_pulse_n) |-> low_q >= 8'd199)
		else $error("strobe low phase too short");
	chk_strobe_ends: assert property (
		$fell(latch_pulse_n) |-> ##[1:400] latch_pulse_n)
		else $error("strobe did not return high");
	chk_word_closed: assert property (
		(rise_q == 4'h8 && $fell(shift_clk)) |-> ##[1:400] !latch_pulse_n)
		else $error("no strobe after a full word");

	cover property ($rose(latch_pulse_n));
	cover property ($rose(shift_clk) && ser_data);
	cover property (rise_q == 4'h8 && $fell(shift_clk));

endmodule // eqs_link_props

`default_nettype wire

// >>> sim/tb_top.sv
// Bench for the host and equalizer ends joined over the three-wire link.
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import eqs_pkg::*;

	typedef struct packed {
		logic [7:0] b, g, sel, gain, open, rng;
	} eqs_row_s;

	// Band word, gain word, then the settings that should result.
	localparam eqs_row_s ROWS [4] = '{
		'{8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00},
		'{8'hCD, 8'h18, 8'h0D, 8'h18, 8'h00, 8'h01},
		'{8'h80, 8'h0C, 8'h00, 8'h0C, 8'h01, 8'h00},
		'{8'h87, 8'h0B, 8'h07, 8'h0B, 8'h00, 8'h00}};

	logic                             clk_sys, reset, start, busy_q, done_q;
	logic [WORD_W-1:0]                band_word, gain_word, last_word, cap;
	logic [BAND_W-1:0]                band_sel, band_sel_b;
	logic [NUM_BANDS-1:0][GAIN_W-1:0] band_gain;
	logic [NUM_BANDS-1:0]             band_open;
	logic                             range_6db, taken, reject;
	logic                             taken_b, reject_b;
	int                               fails, n_compared, n_bits;
	int                               n_taken, n_reject, n_taken_b, n_reject_b;
	logic [WORD_W-1:0]                seen [$]; // Words seen on the wire.

	eqs_link_if link_a ();
	eqs_link_if link_b (); // Driven by the bench to break the word length.

	eqs_host u_eqs_host (.clk_sys(clk_sys), .reset(reset), .link(link_a),
		.start(start), .band_word(band_word), .gain_word(gain_word),
		.busy_q(busy_q), .done_q(done_q));
	eqs_device u_eqs_device (.clk_sys(clk_sys), .reset(reset), .link(link_a),
		.band_sel_q(band_sel), .band_gain_q(band_gain),
		.band_open_q(band_open), .range_6db_q(range_6db),
		.last_word_q(last_word), .word_taken_q(taken), .word_reject_q(reject));
	eqs_device u_eqs_device_b (.clk_sys(clk_sys), .reset(reset),
		.link(link_b), .band_sel_q(band_sel_b), .band_gain_q(),
		.band_open_q(), .range_6db_q(), .last_word_q(),
		.word_taken_q(taken_b), .word_reject_q(reject_b));
	eqs_link_props u_eqs_link_props (.clk_sys(clk_sys), .reset(reset),
		.shift_clk(link_a.shift_clk), .ser_data(link_a.ser_data),
		.latch_pulse_n(link_a.latch_pulse_n));

	////////////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// Pulse counters; pulses stand one cycle, so every edge is looked at.
	always @(posedge clk_sys) begin
		if (taken === 1'b1) n_taken++;
		if (reject === 1'b1) n_reject++;
		if (taken_b === 1'b1) n_taken_b++;
		if (reject_b === 1'b1) n_reject_b++;
	end

	// Rebuild each word from the wire, first bit into bit zero.
	always @(posedge link_a.shift_clk) begin
		cap = {link_a.ser_data, cap[7:1]};
		n_bits++;
	end
	always @(negedge link_a.latch_pulse_n) begin
		seen.push_back(cap);
		chk(8'(n_bits), 8'h08);
		n_bits = 0;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// One host transfer: band word then gain word, bounded wait for done.
	task automatic send(input logic [7:0] b, input logic [7:0] g);
		int n;
		seen.delete();
		n_taken = 0;
		n_reject = 0;
		@(negedge clk_sys);
		start = 1'b1;
		band_word = b;
		gain_word = g;
		@(negedge clk_sys);
		start = 1'b0;
		n = 0;
		while (done_q !== 1'b1 && n < 9000) begin
			@(negedge clk_sys);
			n++;
		end
		chk({7'h00, done_q}, 8'h01);
		chk(seen[0], b);
		chk(seen[1], g);
	endtask

	// Bench-made link clock of 48 ns, stopped outside the frame.
	task automatic send_b(input logic [8:0] w, input int nb);
		for (int i = 0; i < nb; i++) begin
			link_b.ser_data = w[i];
			#24 link_b.shift_clk = 1'b1;
			#24 link_b.shift_clk = 1'b0;
		end
		link_b.ser_data = 1'b0;
		#48 link_b.latch_pulse_n = 1'b0;
		#48 link_b.latch_pulse_n = 1'b1;
		#96;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		#400000;
		fails++;
		conclude();
	end

	initial begin
		{reset, start, band_word, gain_word} = {1'b1, 17'h00000};
		{link_b.shift_clk, link_b.ser_data, link_b.latch_pulse_n} = 3'h1;
		{fails, n_compared, n_bits} = '0;
		repeat (16) @(posedge clk_sys);
		@(negedge clk_sys);
		reset = 1'b0;
		chk({5'h00, link_a.shift_clk, link_a.ser_data,
			link_a.latch_pulse_n}, 8'h01);
		chk({band_sel, 3'h0, range_6db}, 8'h00);
		chk(8'(&band_open), 8'h01);
		chk(last_word, 8'h00);
		for (int i = 0; i < NUM_BANDS; i++) chk(8'(band_gain[i]), 8'h0C);
		foreach (ROWS[i]) begin
			send(ROWS[i].b, ROWS[i].g);
			chk(8'(band_sel), ROWS[i].sel);
			chk(8'(band_gain[ROWS[i].sel[3:0]]), ROWS[i].gain);
			chk(8'(band_open[ROWS[i].sel[3:0]]), ROWS[i].open);
			chk(8'(range_6db), ROWS[i].rng);
			chk(last_word, ROWS[i].g);
			chk(8'(n_taken), 8'h02);
		end
		chk(8'(band_gain[13]), 8'h18);
		// Band fourteen does not exist: gain goes to the band still selected.
		send(8'h8E, 8'h01);
		chk({band_sel, 4'(band_gain[7])}, 8'h71);
		chk(8'(n_reject * 16 + n_taken), 8'h11);
		// Step twenty-five is past the last step and leaves band 3 flat.
		send(8'h83, 8'h19);
		chk({band_sel, 3'h0, band_open[3]}, 8'h31);
		chk(8'(band_gain[3]), 8'h0C);
		chk(8'(n_reject * 16 + n_taken), 8'h11);
		// Short and long words on the second link must be dropped.
		send_b(9'h08A, 7);
		send_b(9'h18A, 9);
		send_b(9'h08A, 8);
		chk(8'(n_reject_b * 16 + n_taken_b), 8'h21);
		chk(8'(band_sel_b), 8'h0A);
		// Reset in mid-word: the host falls quiet, settings go back to flat.
		@(negedge clk_sys);
		{start, band_word, gain_word} = {1'b1, 8'h85, 8'h03};
		@(negedge clk_sys);
		start = 1'b0;
		repeat (1000) @(negedge clk_sys);
		chk(8'(busy_q), 8'h01);
		reset = 1'b1;
		@(negedge clk_sys);
		chk({busy_q, link_a.shift_clk, link_a.ser_data,
			link_a.latch_pulse_n, band_sel}, 8'h10);
		chk(8'(band_gain[7]), 8'h0C);
		n_bits = 0;
		repeat (2) @(negedge clk_sys);
		reset = 1'b0;
		send(8'h85, 8'h03);
		chk({band_sel, 3'h0, band_open[5]}, 8'h50);
		chk(8'(band_gain[5]), 8'h03);
		chk(8'(n_reject * 16 + n_taken), 8'h02);
		conclude();
	end

endmodule // tb_top

`default_nettype wire
